// *** inc/tcc_pkg.sv ***
// constants for the 16-bit timer/counter with input capture
package tcc_pkg;
    // register offsets on the 8-bit register port
    localparam logic [7:0] ADDR_CTRL_A    = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B    = 8'h01;
    localparam logic [7:0] ADDR_CNT_LOW   = 8'h02;
    localparam logic [7:0] ADDR_CNT_HIGH  = 8'h03;
    localparam logic [7:0] ADDR_CAP_LOW   = 8'h04;
    localparam logic [7:0] ADDR_CAP_HIGH  = 8'h05;
    localparam logic [7:0] ADDR_FLAGS     = 8'h06;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h07;
    localparam logic [7:0] ADDR_CMP_CTRL  = 8'h08;
    // control A fields
    localparam int CTRLA_WGM_LSB = 0;      // waveform mode bits 1:0
    // control B fields
    localparam int CTRLB_CS_LSB  = 0;      // clock source select 2:0
    localparam int CTRLB_WGM_LSB = 3;      // waveform mode bits 3:2
    localparam int CTRLB_EDGE    = 6;      // capture edge: 1 rising
    localparam int CTRLB_FILT    = 7;      // capture filter enable
    // flag / enable bit positions
    localparam int FLAG_OVF      = 0;
    localparam int FLAG_CAP      = 5;
    // comparator control field
    localparam int CMP_CAP_SEL   = 2;
    // reset values
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    // counter extremes
    localparam logic [15:0] VAL_BOTTOM  = 16'h0000;
    localparam logic [15:0] VAL_MAX     = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT    = 16'h00FF;
    localparam logic [15:0] TOP_9BIT    = 16'h01FF;
    localparam logic [15:0] TOP_10BIT   = 16'h03FF;
    // filter length in system clock samples
    localparam int FILT_SAMPLES = 4;
    // clock source codes
    localparam logic [2:0] CS_STOP      = 3'h0;
    localparam logic [2:0] CS_DIV1      = 3'h1;
    localparam logic [2:0] CS_DIV8      = 3'h2;
    localparam logic [2:0] CS_DIV64     = 3'h3;
    localparam logic [2:0] CS_DIV256    = 3'h4;
    localparam logic [2:0] CS_DIV1024   = 3'h5;
    localparam logic [2:0] CS_EXT_FALL  = 3'h6;
    localparam logic [2:0] CS_EXT_RISE  = 3'h7;
    // waveform modes that change the count sequence
    localparam logic [3:0] WGM_NORMAL   = 4'h0;
    localparam logic [3:0] WGM_PC8      = 4'h1;
    localparam logic [3:0] WGM_PC9      = 4'h2;
    localparam logic [3:0] WGM_PC10     = 4'h3;
    localparam logic [3:0] WGM_FAST8    = 4'h5;
    localparam logic [3:0] WGM_FAST9    = 4'h6;
    localparam logic [3:0] WGM_FAST10   = 4'h7;
    localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WGM_PC_CAP   = 4'hA;
    localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
    localparam logic [3:0] WGM_FAST_CAP = 4'hE;
endpackage

// *** logic/tcc_counter16.sv ***
// 16-bit up/down counter with input capture and 8-bit register port
module tcc_counter16 (
    input  wire logic       clk_sys,       // system clock 100 MHz
    input  wire logic       rst_n,         // synchronous reset, active low
    input  wire logic [7:0] regAddr,       // register address
    input  wire logic [7:0] regWdata,      // register write data
    input  wire logic       regWr,         // write strobe
    input  wire logic       regRd,         // read strobe
    output logic      [7:0] regRdata,      // read data, cycle after strobe
    input  wire logic       prescaleTick,  // prescaler tap for selected divider
    input  wire logic       extClkPin,     // external count clock pin
    input  wire logic       capturePin,    // capture pin
    input  wire logic       comparatorOut, // comparator output
    input  wire logic       ovfIrqAck,     // overflow interrupt serviced
    input  wire logic       capIrqAck,     // capture interrupt serviced
    output logic            ovfIrq,        // overflow interrupt request
    output logic            capIrq,        // capture interrupt request
    output logic            atTop,         // counter equals top
    output logic            atBottom       // counter equals zero
);
    logic [7:0]  ctrlAReg, ctrlBReg, irqEnReg, cmpCtrlReg, tempReg;
    logic [15:0] countReg, captureReg;
    logic        ovfFlagReg, capFlagReg, upReg;
    logic [1:0]  extSyncReg, capSyncReg, cmpSyncReg;
    logic        extPrevReg, filtOutReg, edgePrevReg;
    localparam int FILT_DEPTH = tcc_pkg::FILT_SAMPLES;
    logic [FILT_DEPTH-2:0] filtShiftReg; // last three samples; the live input is the fourth
    logic [3:0]  wgm;
    logic [2:0]  clkSel;
    logic [15:0] topVal;
    logic        countTick, capTopMode, dualSlope, srcLevel, edgeIn, capEvent, cntLowWr;
    // all checks in this module run on the system clock, off during reset
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // waveform mode split across both control registers
    assign wgm = {ctrlBReg[tcc_pkg::CTRLB_WGM_LSB +: 2], ctrlAReg[tcc_pkg::CTRLA_WGM_LSB +: 2]};
    assign clkSel = ctrlBReg[tcc_pkg::CTRLB_CS_LSB +: 3];
    assign capTopMode = (wgm == tcc_pkg::WGM_PFC_CAP) || (wgm == tcc_pkg::WGM_PC_CAP) ||
                        (wgm == tcc_pkg::WGM_CTC_CAP) || (wgm == tcc_pkg::WGM_FAST_CAP);
    assign dualSlope = (wgm == tcc_pkg::WGM_PC8) || (wgm == tcc_pkg::WGM_PC9) ||
                       (wgm == tcc_pkg::WGM_PC10) || (wgm == tcc_pkg::WGM_PFC_CAP) ||
                       (wgm == tcc_pkg::WGM_PC_CAP);
    assign cntLowWr = regWr && (regAddr == tcc_pkg::ADDR_CNT_LOW);

    // top value chosen by mode
    always_comb begin
        case (wgm)
            tcc_pkg::WGM_PC8, tcc_pkg::WGM_FAST8:   topVal = tcc_pkg::TOP_8BIT;
            tcc_pkg::WGM_PC9, tcc_pkg::WGM_FAST9:   topVal = tcc_pkg::TOP_9BIT;
            tcc_pkg::WGM_PC10, tcc_pkg::WGM_FAST10: topVal = tcc_pkg::TOP_10BIT;
            tcc_pkg::WGM_PFC_CAP, tcc_pkg::WGM_PC_CAP,
            tcc_pkg::WGM_CTC_CAP, tcc_pkg::WGM_FAST_CAP: topVal = captureReg;
            default: topVal = tcc_pkg::VAL_MAX;
        endcase
    end
    assign atTop = (countReg == topVal);
    assign atBottom = (countReg == tcc_pkg::VAL_BOTTOM);

    // synchronizers for pins from outside the clock domain
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            extSyncReg <= 2'h0;
            capSyncReg <= 2'h0;
            cmpSyncReg <= 2'h0;
            extPrevReg <= 1'b0;
        end else begin
            extSyncReg <= {extSyncReg[0], extClkPin};
            capSyncReg <= {capSyncReg[0], capturePin};
            cmpSyncReg <= {cmpSyncReg[0], comparatorOut};
            extPrevReg <= extSyncReg[1];
        end
    end

    // count clock selection; zero selects no clock
    always_comb begin
        case (clkSel)
            tcc_pkg::CS_STOP:     countTick = 1'b0;
            tcc_pkg::CS_DIV1:     countTick = 1'b1;
            tcc_pkg::CS_EXT_FALL: countTick = extPrevReg && !extSyncReg[1];
            tcc_pkg::CS_EXT_RISE: countTick = !extPrevReg && extSyncReg[1];
            default:              countTick = prescaleTick;
        endcase
    end

    // counter: cpu write first, then clear or count per mode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            countReg <= tcc_pkg::RST_WORD;
            upReg <= 1'b1;
        end else if (cntLowWr) begin
            countReg <= {tempReg, regWdata};
        end else if (countTick) begin
            if (dualSlope) begin
                if (upReg && atTop) begin
                    upReg <= 1'b0;
                    countReg <= countReg - 16'h0001;
                end else if (!upReg && atBottom) begin
                    upReg <= 1'b1;
                    countReg <= countReg + 16'h0001;
                end else if (upReg) begin
                    countReg <= countReg + 16'h0001;
                end else begin
                    countReg <= countReg - 16'h0001;
                end
            end else begin
                upReg <= 1'b1;
                if (atTop && (wgm != tcc_pkg::WGM_NORMAL)) begin
                    countReg <= tcc_pkg::VAL_BOTTOM;
                end else begin
                    countReg <= countReg + 16'h0001;
                end
            end
        end
    end

    // capture source select and optional noise filter
    assign srcLevel = cmpCtrlReg[tcc_pkg::CMP_CAP_SEL] ? cmpSyncReg[1] : capSyncReg[1];
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            filtShiftReg <= '0;
            filtOutReg <= 1'b0;
        end else begin
            filtShiftReg <= {filtShiftReg[FILT_DEPTH-3:0], srcLevel};
            // live sample counted in, so the filter adds four cycles, not five
            if (&{filtShiftReg, srcLevel}) begin
                filtOutReg <= 1'b1;
            end else if (~|{filtShiftReg, srcLevel}) begin
                filtOutReg <= 1'b0;
            end
        end
    end
    assign edgeIn = ctrlBReg[tcc_pkg::CTRLB_FILT] ? filtOutReg : srcLevel;

    // edge detector, blocked in capture-top modes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            edgePrevReg <= 1'b0;
        end else begin
            edgePrevReg <= edgeIn;
        end
    end
    assign capEvent = !capTopMode && (edgeIn != edgePrevReg) &&
                      (edgeIn == ctrlBReg[tcc_pkg::CTRLB_EDGE]);

    // capture register: event overwrites, cpu writes only in top modes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            captureReg <= tcc_pkg::RST_WORD;
        end else if (capEvent) begin
            captureReg <= countReg;
        end else if (regWr && capTopMode && (regAddr == tcc_pkg::ADDR_CAP_LOW)) begin
            captureReg <= {tempReg, regWdata};
        end
    end

    // shared temporary high byte
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tempReg <= tcc_pkg::RST_BYTE;
        end else if (regRd && (regAddr == tcc_pkg::ADDR_CNT_LOW)) begin
            tempReg <= countReg[15:8];
        end else if (regRd && (regAddr == tcc_pkg::ADDR_CAP_LOW)) begin
            tempReg <= captureReg[15:8];
        end else if (regWr && ((regAddr == tcc_pkg::ADDR_CNT_HIGH) || (regAddr == tcc_pkg::ADDR_CAP_HIGH))) begin
            tempReg <= regWdata;
        end
    end

    // flags: set wins over clear by ack or written one
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ovfFlagReg <= 1'b0;
            capFlagReg <= 1'b0;
        end else begin
            if (countTick && !cntLowWr && (dualSlope ? (!upReg && atBottom) : atTop)) begin
                ovfFlagReg <= 1'b1;
            end else if (ovfIrqAck || (regWr && (regAddr == tcc_pkg::ADDR_FLAGS) && regWdata[tcc_pkg::FLAG_OVF])) begin
                ovfFlagReg <= 1'b0;
            end
            if (capEvent) begin
                capFlagReg <= 1'b1;
            end else if (capIrqAck || (regWr && (regAddr == tcc_pkg::ADDR_FLAGS) && regWdata[tcc_pkg::FLAG_CAP])) begin
                capFlagReg <= 1'b0;
            end
        end
    end
    assign ovfIrq = ovfFlagReg && irqEnReg[tcc_pkg::FLAG_OVF];
    assign capIrq = capFlagReg && irqEnReg[tcc_pkg::FLAG_CAP];

    // plain control registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrlAReg <= tcc_pkg::RST_BYTE;
            ctrlBReg <= tcc_pkg::RST_BYTE;
            irqEnReg <= tcc_pkg::RST_BYTE;
            cmpCtrlReg <= tcc_pkg::RST_BYTE;
        end else if (regWr) begin
            if (regAddr == tcc_pkg::ADDR_CTRL_A) ctrlAReg <= regWdata;
            if (regAddr == tcc_pkg::ADDR_CTRL_B) ctrlBReg <= regWdata;
            if (regAddr == tcc_pkg::ADDR_IRQ_EN) irqEnReg <= regWdata;
            if (regAddr == tcc_pkg::ADDR_CMP_CTRL) cmpCtrlReg <= regWdata;
        end
    end

    // read data one cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdata <= tcc_pkg::RST_BYTE;
        end else if (regRd) begin
            case (regAddr)
                tcc_pkg::ADDR_CTRL_A:   regRdata <= ctrlAReg;
                tcc_pkg::ADDR_CTRL_B:   regRdata <= ctrlBReg;
                tcc_pkg::ADDR_CNT_LOW:  regRdata <= countReg[7:0];
                tcc_pkg::ADDR_CNT_HIGH: regRdata <= tempReg;
                tcc_pkg::ADDR_CAP_LOW:  regRdata <= captureReg[7:0];
                tcc_pkg::ADDR_CAP_HIGH: regRdata <= tempReg;
                tcc_pkg::ADDR_FLAGS:    regRdata <= {2'h0, capFlagReg, 4'h0, ovfFlagReg};
                tcc_pkg::ADDR_IRQ_EN:   regRdata <= irqEnReg;
                tcc_pkg::ADDR_CMP_CTRL: regRdata <= cmpCtrlReg;
                default:                regRdata <= tcc_pkg::RST_BYTE;
            endcase
        end else begin
            regRdata <= tcc_pkg::RST_BYTE;
        end
    end

    a_stop_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clkSel == tcc_pkg::CS_STOP) && !cntLowWr |=> $stable(countReg))
        else $error("counter moved while stopped");
    a_write_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cntLowWr |=> countReg == {$past(tempReg), $past(regWdata)})
        else $error("low byte write did not load counter");
    a_low_read_temp: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regRd && (regAddr == tcc_pkg::ADDR_CNT_LOW) |=> tempReg == $past(countReg[15:8]))
        else $error("temp not loaded on low read");
    a_cap_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
        capEvent |=> (captureReg == $past(countReg)) && capFlagReg)
        else $error("capture did not copy counter");
    a_cap_topmode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        capTopMode |-> !capEvent)
        else $error("capture in capture-top mode");
    a_filter_four: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(filtOutReg) |-> $past({filtShiftReg, srcLevel}) == {FILT_DEPTH{filtOutReg}})
        else $error("filter changed without four equal samples");
    a_cap_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
        capIrq |-> capFlagReg && irqEnReg[tcc_pkg::FLAG_CAP])
        else $error("capture irq without flag");
    a_bottom_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        atBottom == (countReg == 16'h0000))
        else $error("bottom indication wrong");
    a_ovf_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        countTick && !cntLowWr && !dualSlope && atTop |=> ovfFlagReg)
        else $error("overflow flag not set at top");

    // four equal samples in a row at the filter input
    sequence s_src_high4;
        srcLevel [*4];
    endsequence
    sequence s_src_low4;
        !srcLevel [*4];
    endsequence
    // counter high byte reads return temp
    a_cnt_high_rd: assert property (
        regRd && (regAddr == tcc_pkg::ADDR_CNT_HIGH) |=> regRdata == $past(tempReg))
        else $error("counter high read not from temp");
    // capture high byte reads return temp
    a_cap_high_rd: assert property (
        regRd && (regAddr == tcc_pkg::ADDR_CAP_HIGH) |=> regRdata == $past(tempReg))
        else $error("capture high read not from temp");
    // capture low read loads temp with the upper byte
    a_cap_low_temp: assert property (
        regRd && (regAddr == tcc_pkg::ADDR_CAP_LOW) |=> tempReg == $past(captureReg[15:8]))
        else $error("temp not loaded on capture low read");
    // one temp byte behind every high location
    a_temp_shared: assert property (
        regWr && !regRd && (regAddr == tcc_pkg::ADDR_CAP_HIGH) |=> tempReg == $past(regWdata))
        else $error("capture high write missed temp");
    // a high write never reaches a stopped counter
    a_cnt_high_wr: assert property (
        regWr && (regAddr == tcc_pkg::ADDR_CNT_HIGH) && (clkSel == tcc_pkg::CS_STOP) |=> $stable(countReg))
        else $error("high write reached counter");
    // low byte read shows the live counter
    a_cnt_low_rd: assert property (
        regRd && (regAddr == tcc_pkg::ADDR_CNT_LOW) |=> regRdata == $past(countReg[7:0]))
        else $error("counter low read wrong");
    // single slope steps up below top
    a_count_up: assert property (
        countTick && !cntLowWr && !dualSlope && !atTop |=> countReg == $past(countReg) + 16'h0001)
        else $error("counter did not step up");
    // fixed or register top wraps to bottom
    a_top_clear: assert property (
        countTick && !cntLowWr && !dualSlope && atTop && (wgm != tcc_pkg::WGM_NORMAL) |=>
        countReg == tcc_pkg::VAL_BOTTOM)
        else $error("counter did not clear at top");
    // dual slope turns down at top
    a_dual_turn: assert property (
        countTick && !cntLowWr && dualSlope && upReg && atTop |=> !upReg)
        else $error("dual slope did not turn at top");
    // a selected rising edge captures outside capture-top modes
    a_edge_capture: assert property (
        !capTopMode && $rose(edgeIn) && ctrlBReg[tcc_pkg::CTRLB_EDGE] |-> capEvent)
        else $error("rising edge not captured");
    // comparator feeds the edge detector when selected
    a_cmp_source: assert property (
        cmpCtrlReg[tcc_pkg::CMP_CAP_SEL] && !ctrlBReg[tcc_pkg::CTRLB_FILT] |-> edgeIn == cmpSyncReg[1])
        else $error("comparator not used as source");
    // service clears the capture flag
    a_cap_ack: assert property (
        capIrqAck && !capEvent |=> !capFlagReg)
        else $error("capture flag kept after service");
    // pin reaches logic through two flops
    a_sync_depth: assert property (
        capSyncReg[1] == $past(capturePin, 2))
        else $error("capture pin sync depth wrong");
    // filter samples every system clock
    a_filt_sample: assert property (
        filtShiftReg[0] == $past(srcLevel))
        else $error("filter missed a sample");
    // four high samples raise the filter output next cycle
    a_filt_rise: assert property (
        s_src_high4 |=> filtOutReg)
        else $error("filter late on rising input");
    // four low samples drop the filter output next cycle
    a_filt_fall: assert property (
        s_src_low4 |=> !filtOutReg)
        else $error("filter late on falling input");
endmodule // tcc_counter16

// *** bench/tcc_cpu_model.sv ***
// register-port master standing in for the cpu core
module tcc_cpu_model (
    input  wire logic       clk_sys,  // system clock
    output logic      [7:0] regAddr,  // register address
    output logic      [7:0] regWdata, // write data
    output logic            regWr,    // write strobe
    output logic            regRd,    // read strobe
    input  wire logic [7:0] regRdata  // read data, cycle after strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    time tTake; // edge that took the last strobe
    time tLow;  // edge that took the last low-byte read
    // idle bus at time zero
    initial begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // one write cycle, data inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        tTake = $time;
        regWr <= 1'b0;
        regWdata <= ~d;
    endtask
    // one read cycle, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        tTake = $time;
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    // high byte first, the low write loads the word
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo + 8'h01, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    // low byte first, so the high byte comes from temp
    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        logic [7:0] l;
        logic [7:0] h;
        rd(lo, l);
        tLow = tTake;
        rd(lo + 8'h01, h);
        v = {h, l};
    endtask
endmodule // tcc_cpu_model

// *** bench/tb.sv ***
// self-checking bench for the 16-bit timer/counter with capture
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CNT  = tcc_pkg::ADDR_CNT_LOW;       // counter low
    localparam logic [7:0] CAP  = tcc_pkg::ADDR_CAP_LOW;       // capture low
    localparam logic [7:0] FLG  = tcc_pkg::ADDR_FLAGS;         // flags
    localparam logic [7:0] CTB  = tcc_pkg::ADDR_CTRL_B;        // control b
    localparam logic [7:0] IEN  = tcc_pkg::ADDR_IRQ_EN;        // irq enable
    localparam logic [7:0] CAPB = 8'h01 << tcc_pkg::FLAG_CAP;  // capture bit
    localparam logic [7:0] OVFB = 8'h01 << tcc_pkg::FLAG_OVF;  // overflow bit
    logic        clk_sys, rst_n, prescaleTick, extClkPin, capturePin;
    logic        comparatorOut, ovfIrqAck, capIrqAck, regWr, regRd;
    logic [7:0]  regAddr, regWdata, regRdata, b;
    logic        ovfIrq, capIrq, atTop, atBottom;
    logic [15:0] v, got;
    int          errors, num_checks, seed, n, d0;
    time         t1;
    tcc_counter16 i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .prescaleTick(prescaleTick), .extClkPin(extClkPin), .capturePin(capturePin),
        .comparatorOut(comparatorOut), .ovfIrqAck(ovfIrqAck), .capIrqAck(capIrqAck),
        .ovfIrq(ovfIrq), .capIrq(capIrq), .atTop(atTop), .atBottom(atBottom));
    tcc_cpu_model i_cpu (.clk_sys(clk_sys), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    // control b byte from its fields
    function automatic logic [7:0] cb(logic [2:0] cs, logic [3:0] wg, logic ed, logic fl);
        return {fl, ed, 1'b0, wg[3:2], cs};
    endfunction
    // compare and count
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string s);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, s, g, e);
        end
    endtask
    // counts and verdict
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // move a source, count cycles until the capture irq shows (20 = none)
    task automatic cap_wait(input logic cmp, input logic lvl, output int k);
        @(posedge clk_sys);
        if (cmp) comparatorOut <= lvl;
        else capturePin <= lvl;
        k = 0;
        while (capIrq !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
    endtask
    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        $display("wrong value at %0t: run timed out", $time);
        wrap_up();
    end
    // main sequence
    initial begin
        {rst_n, extClkPin, capturePin, comparatorOut, ovfIrqAck, capIrqAck} = 6'h00;
        prescaleTick = 1'b1;
        errors = 0;
        num_checks = 0;
        seed = 32'h32e5;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            i_cpu.rd(8'(a), b);
            chk(16'(b), 16'h0000, "reset or unmapped read");
        end
        chk(16'(atBottom), 16'h0001, "bottom flag at zero");
        $display("end: reset");
        repeat (4) begin
            v = 16'($random(seed));
            i_cpu.wr16(CNT, v);
            repeat (3) @(posedge clk_sys);
            i_cpu.rd16(CNT, got);
            chk(got, v, "stopped counter held");
        end
        i_cpu.wr(CAP + 8'h01, 8'h5a);
        i_cpu.wr(CNT, 8'hc3);
        i_cpu.wr(CNT + 8'h01, 8'h77);
        i_cpu.rd16(CNT, got);
        chk(got, 16'h5ac3, "shared temp, high byte indirect");
        chk(got, 16'h5ac3, "high write alone leaves counter");
        $display("end: access while stopped");
        for (int cs = 1; cs < 6; cs++) begin
            i_cpu.wr16(CNT, 16'h00fd);
            i_cpu.wr(CTB, cb(3'(cs), tcc_pkg::WGM_NORMAL, 1'b0, 1'b0));
            i_cpu.rd16(CNT, v);
            t1 = i_cpu.tLow;
            i_cpu.rd16(CNT, got);
            chk(got, v + 16'((i_cpu.tLow - t1) / 10), "count step");
        end
        v = 16'($random(seed));
        i_cpu.wr16(CNT, v);
        t1 = i_cpu.tTake;
        i_cpu.rd16(CNT, got);
        chk(got, v + 16'((i_cpu.tLow - t1) / 10 - 1), "write beats count");
        i_cpu.wr(tcc_pkg::ADDR_CTRL_A, 8'h01);
        i_cpu.wr(CTB, cb(tcc_pkg::CS_DIV1, tcc_pkg::WGM_FAST8, 1'b0, 1'b0));
        i_cpu.wr16(CNT, 16'h00fc);
        t1 = i_cpu.tTake;
        repeat (6) @(posedge clk_sys);
        i_cpu.rd16(CNT, got);
        chk(got, (16'h00fc + 16'((i_cpu.tLow - t1) / 10) - 16'h0001) & tcc_pkg::TOP_8BIT, "8-bit wrap");
        i_cpu.wr(tcc_pkg::ADDR_CTRL_A, 8'h00);
        $display("end: counting");
        i_cpu.wr(IEN, OVFB | CAPB);
        i_cpu.wr16(CNT, 16'hfff8);
        i_cpu.wr(FLG, OVFB);
        n = 0;
        while (ovfIrq !== 1'b1 && n < 30) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(16'(n < 30), 16'h0001, "overflow raised");
        i_cpu.wr(CTB, 8'h00);
        ovfIrqAck <= 1'b1;
        @(posedge clk_sys);
        ovfIrqAck <= 1'b0;
        #1;
        chk(16'(ovfIrq), 16'h0000, "overflow ack clears");
        $display("end: overflow");
        for (int f = 0; f < 2; f++) begin
            v = 16'($random(seed));
            i_cpu.wr(CTB, cb(tcc_pkg::CS_STOP, tcc_pkg::WGM_NORMAL, 1'b1, 1'(f)));
            i_cpu.wr16(CNT, v);
            i_cpu.wr(FLG, CAPB);
            cap_wait(1'b0, 1'b1, n);
            if (f == 1) chk(16'(n - d0), 16'd4, "filter delay");
            d0 = n;
            i_cpu.rd16(CAP, got);
            chk(got, v, "capture stamp");
            i_cpu.wr(FLG, CAPB);
            cap_wait(1'b0, 1'b0, n);
            chk(16'(n), 16'd20, "falling ignored when rising set");
        end
        @(posedge clk_sys);
        capturePin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        capturePin <= 1'b0;
        cap_wait(1'b0, 1'b0, n);
        chk(16'(n), 16'd20, "short pulse filtered");
        $display("end: capture and filter");
        i_cpu.wr(CTB, cb(tcc_pkg::CS_STOP, tcc_pkg::WGM_NORMAL, 1'b0, 1'b0));
        cap_wait(1'b0, 1'b1, n);
        chk(16'(n), 16'd20, "rising ignored when falling set");
        cap_wait(1'b0, 1'b0, n);
        v = 16'($random(seed));
        i_cpu.wr16(CNT, v);
        i_cpu.wr(FLG, CAPB);
        cap_wait(1'b0, 1'b1, n);
        cap_wait(1'b0, 1'b0, n);
        i_cpu.rd16(CAP, got);
        chk(got, v, "unread capture overwritten");
        i_cpu.wr(CTB, cb(tcc_pkg::CS_STOP, tcc_pkg::WGM_NORMAL, 1'b1, 1'b0));
        i_cpu.wr(tcc_pkg::ADDR_CMP_CTRL, 8'h01 << tcc_pkg::CMP_CAP_SEL);
        i_cpu.wr(FLG, CAPB);
        cap_wait(1'b0, 1'b1, n);
        chk(16'(n), 16'd20, "pin ignored with comparator source");
        v = 16'($random(seed));
        i_cpu.wr16(CNT, v);
        cap_wait(1'b1, 1'b1, n);
        i_cpu.rd16(CAP, got);
        chk(got, v, "comparator capture");
        i_cpu.wr(IEN, 8'h00);
        #1;
        chk(16'(capIrq), 16'h0000, "capture irq masked");
        i_cpu.rd(FLG, b);
        chk(16'(b & CAPB), 16'(CAPB), "flag kept while masked");
        i_cpu.wr(IEN, CAPB);
        capIrqAck <= 1'b1;
        @(posedge clk_sys);
        capIrqAck <= 1'b0;
        #1;
        chk(16'(capIrq), 16'h0000, "service clears capture flag");
        $display("end: source and irq");
        i_cpu.wr(CTB, cb(tcc_pkg::CS_STOP, tcc_pkg::WGM_CTC_CAP, 1'b1, 1'b0));
        i_cpu.wr16(CAP, 16'h1234);
        i_cpu.rd16(CAP, got);
        chk(got, 16'h1234, "capture written in top mode");
        cap_wait(1'b1, 1'b0, n);
        cap_wait(1'b1, 1'b1, n);
        chk(16'(n), 16'd20, "no capture in top mode");
        i_cpu.wr(CTB, cb(tcc_pkg::CS_STOP, tcc_pkg::WGM_NORMAL, 1'b1, 1'b0));
        i_cpu.wr16(CAP, 16'hbeef);
        i_cpu.rd16(CAP, got);
        chk(got, 16'h1234, "capture write refused");
        $display("end: capture as top");
        wrap_up();
    end
endmodule // tb
